// ==== host_model.sv ====
// Purpose: Host that programs the chopper control registers over Avalon-MM
// Assumes: One request at a time; the slave answers through waitrequest
// Notes:   No bound on the wait; only the bench watchdog ends a hang
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic        ref_clk,
    // Avalon-MM master side
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
    end

    // Threshold and config values come from the caller as whole words
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        // Released data must not look like a held value
        avs_writedata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read    <= 1'b0;
    endtask : rd
endmodule : host_model

// ==== pin_sync3.sv ====
// Purpose: Three-stage synchroniser for pin inputs with agreement filter
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
module pin_sync3 #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_s;

    sync_state_s st;
    sync_state_s next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Both agree: follow them; disagree: keep the old level
        next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.q;

endmodule : pin_sync3

// ==== quiet_chop_pkg.sv ====
// Purpose: Shared constants and carriers for the quiet chopper mode control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   PWM config and status word layouts are packed structs; config flag and threshold use bare bit positions
package quiet_chop_pkg;

    // Register byte offsets
    localparam logic [7:0] GLOBAL_CONFIG_OFS      = 8'h00;
    localparam logic [7:0] QUIET_THRESHOLD_OFS    = 8'h04;
    localparam logic [7:0] PWM_CONFIG_OFS         = 8'h08;
    localparam logic [7:0] STEP_INTERVAL_OFS      = 8'h0c;
    localparam logic [7:0] CHOPPER_STATUS_OFS     = 8'h10;

    // Widths and limits
    localparam int         INTERVAL_W             = 20;
    localparam logic [19:0] INTERVAL_MAX          = 20'hfffff;
    localparam logic [19:0] INTERVAL_ONE          = 20'h00001;
    localparam logic [19:0] THRESHOLD_RST         = 20'h00000;
    localparam logic [8:0]  SCALE_MAX             = 9'h1ff;
    localparam logic [8:0]  SCALE_RST             = 9'h000;
    localparam logic [3:0]  LIMIT_LOW_BITS        = 4'h0;
    localparam logic [7:0]  AMPLITUDE_MAX         = 8'hff;

    // Effective PWM period in half-clock units: counter steps by two per clock
    localparam logic [10:0] PWM_STEP              = 11'h002;
    localparam logic [10:0] PWM_DIV_0             = 11'h400;
    localparam logic [10:0] PWM_DIV_1             = 11'h2ab;
    localparam logic [10:0] PWM_DIV_2             = 11'h200;
    localparam logic [10:0] PWM_DIV_3             = 11'h19a;
    localparam logic [15:0] PWM_GAP_SEL0          = 16'h01ff;

    typedef enum logic [1:0] {
        FREQ_DIV_1024 = 2'b00,
        FREQ_DIV_683  = 2'b01,
        FREQ_DIV_512  = 2'b10,
        FREQ_DIV_410  = 2'b11
    } freq_sel_e;

    typedef struct packed {
        logic [7:0] user_offset_value;
        logic [7:0] user_gradient_value;
        logic [3:0] regulation_gain;
        logic [1:0] rsv_hi;
        freq_sel_e  chopper_frequency_select;
        logic [1:0] rsv_lo;
        logic       auto_gradient_en;
        logic       auto_scale_en;
        logic [3:0] switch_amplitude_limit;
    } pwm_conf_s;

    localparam pwm_conf_s PWM_CONF_RST = '{
        user_offset_value: 8'h00, user_gradient_value: 8'h00, regulation_gain: 4'h1,
        rsv_hi: 2'h0, chopper_frequency_select: FREQ_DIV_1024, rsv_lo: 2'h0,
        auto_gradient_en: 1'b0, auto_scale_en: 1'b0, switch_amplitude_limit: 4'hc};

    typedef struct packed {
        logic [11:0] rsv;
        logic        chopper_phase;
        logic        select_pin;
        logic        disable_effective;
        logic        quiet_active;
        logic [7:0]  tuned_gradient_value;
        logic [7:0]  amplitude;
    } chop_status_s;

    // Whole state of the control block
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        force_current_chopper;
        logic [19:0] threshold;
        pwm_conf_s   conf;
        logic [19:0] interval_cnt;
        logic [19:0] interval;
        logic        step_prev;
        logic        quiet;
        logic [8:0]  scale;
        logic [7:0]  tuned_grad;
        logic [10:0] pwm_cnt;
        logic        pwm_tick;
        logic        phase;
    } ctrl_state_s;

endpackage : quiet_chop_pkg

// ==== quiet_chopper_mode_control.sv ====
// Purpose: Chooses quiet voltage chopper or cycle-based current chopper and holds its tuning
// Assumes: Microstep and chopper-select arrive as pins; fullstep and current error are local
// Notes:   Step interval is measured in ref_clk cycles; one wait state on every bus access
`timescale 1ns/100ps
module quiet_chopper_mode_control
    import quiet_chop_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Avalon-MM register slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Pins
    input  wire logic        microstep_pin,
    input  wire logic        chopper_select_pin,
    // Local motion and current feedback
    input  wire logic        fullstep_pulse,
    input  wire logic [7:0]  velocity_level,
    input  wire logic signed [7:0] current_error,
    // Chopper control outputs
    output logic             quiet_chopper_active,
    output logic             current_chopper_active,
    output logic [7:0]       amplitude,
    output logic [7:0]       gradient_in_use,
    output logic             pwm_cycle_start,
    output logic             chopper_phase
);

    ctrl_state_s  st;
    ctrl_state_s  next_st;
    logic [1:0]   pins_level;
    logic         step_level;
    logic         select_level;
    logic         disable_eff;
    logic         step_edge;
    logic [31:0]  be_mask;
    logic         bus_commit;
    logic [15:0]  grad_product;
    logic [8:0]   fwd_sum;
    logic [7:0]   fwd_amp;
    logic [8:0]   fwd_target;
    logic [8:0]   switch_limit;
    logic [10:0]  pwm_div;
    logic [10:0]  pwm_sum;
    logic [9:0]   scale_up;
    logic [8:0]   gain_ext;
    chop_status_s status_word;

    pin_sync3 #(
        .W(2)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_in  ({chopper_select_pin, microstep_pin}),
        .level   (pins_level)
    );

    assign step_level   = pins_level[0];
    assign select_level = pins_level[1];

    always_comb begin
        next_st = st;

        // Bus: request waits one cycle, commits on the edge where waitrequest is low
        avs_waitrequest = (avs_read | avs_write) & ~st.ack;
        bus_commit      = avs_write & st.ack;
        next_st.ack     = (avs_read | avs_write) & ~st.ack;
        be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

        disable_eff = st.force_current_chopper ^ select_level;
        step_edge   = step_level & ~st.step_prev;
        next_st.step_prev = step_level;

        status_word = '{rsv: 12'h000, chopper_phase: st.phase, select_pin: select_level,
                        disable_effective: disable_eff, quiet_active: st.quiet,
                        tuned_gradient_value: st.tuned_grad, amplitude: st.scale[8:1]};

        if (avs_read & ~st.ack) begin
            case (avs_address)
                GLOBAL_CONFIG_OFS:   next_st.rdata = {31'h00000000, st.force_current_chopper};
                QUIET_THRESHOLD_OFS: next_st.rdata = {12'h000, st.threshold};
                PWM_CONFIG_OFS:      next_st.rdata = st.conf;
                STEP_INTERVAL_OFS:   next_st.rdata = {12'h000, st.interval};
                CHOPPER_STATUS_OFS:  next_st.rdata = status_word;
                default:             next_st.rdata = 32'h00000000;
            endcase
        end

        if (bus_commit) begin
            case (avs_address)
                GLOBAL_CONFIG_OFS: begin
                    if (avs_byteenable[0]) begin
                        next_st.force_current_chopper = avs_writedata[0];
                    end
                end
                QUIET_THRESHOLD_OFS: begin
                    // Full 20-bit range accepted, upper bits of the word read as zero
                    next_st.threshold = (st.threshold & ~be_mask[19:0])
                                      | (avs_writedata[19:0] & be_mask[19:0]);
                end
                PWM_CONFIG_OFS: begin
                    next_st.conf = (st.conf & ~be_mask) | (avs_writedata & be_mask);
                    next_st.conf.rsv_hi = 2'h0;
                    next_st.conf.rsv_lo = 2'h0;
                end
                default: begin
                end
            endcase
        end

        // Interval measurement in clock cycles, saturating at standstill
        if (step_edge) begin
            next_st.interval     = st.interval_cnt;
            next_st.interval_cnt = INTERVAL_ONE;
        end else if (st.interval_cnt == INTERVAL_MAX) begin
            next_st.interval = INTERVAL_MAX;
        end else begin
            next_st.interval_cnt = st.interval_cnt + INTERVAL_ONE;
        end

        // Decision uses the latest measurement, so it follows every new interval
        next_st.quiet = ~disable_eff & (st.interval >= st.threshold);

        // PWM period: counter advances by two per clock and wraps at the divider
        case (st.conf.chopper_frequency_select)
            FREQ_DIV_1024: pwm_div = PWM_DIV_0;
            FREQ_DIV_683:  pwm_div = PWM_DIV_1;
            FREQ_DIV_512:  pwm_div = PWM_DIV_2;
            FREQ_DIV_410:  pwm_div = PWM_DIV_3;
            default:       pwm_div = PWM_DIV_0;
        endcase
        pwm_sum          = st.pwm_cnt + PWM_STEP;
        next_st.pwm_tick = 1'b0;
        if (pwm_sum >= pwm_div) begin
            next_st.pwm_cnt  = pwm_sum - pwm_div;
            next_st.pwm_tick = 1'b1;
            next_st.phase    = ~st.phase;
        end else begin
            next_st.pwm_cnt  = pwm_sum;
        end

        // Gradient: user value unless automatic tuning runs
        if (!st.conf.auto_gradient_en) begin
            next_st.tuned_grad = st.conf.user_gradient_value;
        end else if (fullstep_pulse && st.quiet) begin
            if (current_error > 8'sh00 && st.tuned_grad != AMPLITUDE_MAX) begin
                next_st.tuned_grad = st.tuned_grad + 8'h01;
            end else if (current_error < 8'sh00 && st.tuned_grad != 8'h00) begin
                next_st.tuned_grad = st.tuned_grad - 8'h01;
            end
        end

        // Forward amplitude: offset plus gradient weighted by velocity
        // Widen both factors first so the full 16-bit product is kept
        grad_product = {8'h00, st.tuned_grad} * {8'h00, velocity_level};
        fwd_sum      = {1'b0, st.conf.user_offset_value} + {1'b0, grad_product[15:8]};
        fwd_amp      = fwd_sum[8] ? AMPLITUDE_MAX : fwd_sum[7:0];
        fwd_target   = {fwd_amp, 1'b0};
        switch_limit = {st.conf.switch_amplitude_limit, LIMIT_LOW_BITS, 1'b0};
        gain_ext     = {5'h00, st.conf.regulation_gain};
        scale_up     = {1'b0, st.scale} + {1'b0, gain_ext};

        // Scale holds one fractional bit so gain one gives half a step
        if (!st.conf.auto_scale_en) begin
            if (!st.quiet) begin
                next_st.scale = fwd_target;
            end else if (st.pwm_tick && st.scale < fwd_target) begin
                next_st.scale = st.scale + 9'h001;
            end else if (st.pwm_tick && st.scale > fwd_target) begin
                next_st.scale = st.scale - 9'h001;
            end
        end else if (fullstep_pulse && st.quiet) begin
            // Frozen while the current chopper runs
            if (current_error > 8'sh00) begin
                next_st.scale = scale_up[9] ? SCALE_MAX : scale_up[8:0];
            end else if (current_error < 8'sh00) begin
                next_st.scale = (st.scale > gain_ext) ? st.scale - gain_ext : SCALE_RST;
            end
        end

        // Switching into the quiet chopper caps the amplitude
        if (next_st.quiet && !st.quiet && next_st.scale > switch_limit) begin
            next_st.scale = switch_limit;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{ack: 1'b0, rdata: 32'h00000000, force_current_chopper: 1'b0,
                    threshold: THRESHOLD_RST, conf: PWM_CONF_RST,
                    interval_cnt: INTERVAL_ONE, interval: INTERVAL_MAX, step_prev: 1'b0,
                    quiet: 1'b0, scale: SCALE_RST, tuned_grad: 8'h00,
                    pwm_cnt: 11'h000, pwm_tick: 1'b0, phase: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata           = st.rdata;
    assign quiet_chopper_active   = st.quiet;
    assign current_chopper_active = ~st.quiet;
    assign amplitude              = st.scale[8:1];
    assign gradient_in_use        = st.tuned_grad;
    assign pwm_cycle_start        = st.pwm_tick;
    assign chopper_phase          = st.phase;

    // Helper: spacing between PWM ticks while the frequency select stays put
    logic [15:0] tick_gap;
    logic        gap_valid;
    logic [1:0]  sel_seen;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_gap  <= 16'h0000;
            gap_valid <= 1'b0;
            sel_seen  <= 2'h0;
        end else begin
            sel_seen <= st.conf.chopper_frequency_select;
            if (st.pwm_tick) begin
                tick_gap  <= 16'h0000;
                gap_valid <= 1'b1;
            end else begin
                tick_gap  <= tick_gap + 16'h0001;
            end
            if (sel_seen != st.conf.chopper_frequency_select) begin
                gap_valid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_flag_blocks_quiet: assert property (
        (st.force_current_chopper && !select_level) |=> !st.quiet)
        else $error("quiet chopper active while configuration flag forbids it");

    a_pin_xor_enable: assert property (
        (st.force_current_chopper && select_level && st.interval >= st.threshold)
        |=> st.quiet)
        else $error("pin did not invert the configuration flag");

    a_threshold_write: assert property (
        (bus_commit && avs_address == QUIET_THRESHOLD_OFS && avs_byteenable == 4'hf)
        |=> st.threshold == $past(avs_writedata[19:0]))
        else $error("threshold write not stored");

    a_interval_latch: assert property (
        step_edge |=> (st.interval == $past(st.interval_cnt)) && st.interval_cnt == INTERVAL_ONE)
        else $error("step interval not latched on microstep");

    a_fast_disables: assert property (
        (st.interval < st.threshold) |=> !st.quiet)
        else $error("quiet chopper kept above threshold velocity");

    a_switch_limit: assert property (
        $rose(st.quiet) |-> st.scale <= {$past(st.conf.switch_amplitude_limit),
                                          LIMIT_LOW_BITS, 1'b0})
        else $error("amplitude above switch limit on entering quiet chopper");

    a_forward_track: assert property (
        (!st.conf.auto_scale_en && !st.quiet) ##1 !st.quiet |-> st.scale == $past(fwd_target))
        else $error("forward amplitude not followed");

    a_user_gradient: assert property (
        !st.conf.auto_gradient_en |=> st.tuned_grad == $past(st.conf.user_gradient_value))
        else $error("user gradient not used with tuning off");

    a_pwm_period: assert property (
        (st.pwm_tick && gap_valid && st.conf.chopper_frequency_select == FREQ_DIV_1024
         && sel_seen == FREQ_DIV_1024)
        |-> tick_gap == PWM_GAP_SEL0)
        else $error("PWM period wrong for setting zero");

    a_phase_toggle: assert property (
        st.pwm_tick |-> st.phase != $past(st.phase))
        else $error("chopper output did not toggle on PWM period");

    a_gain_step: assert property (
        (st.conf.auto_scale_en && fullstep_pulse && st.quiet && !disable_eff
         && st.interval >= st.threshold && current_error > 8'sh00 && !scale_up[9])
        |=> st.scale == $past(scale_up[8:0]))
        else $error("regulation step not equal to gain");

endmodule : quiet_chopper_mode_control

// ==== testbench.sv ====
// Purpose: Self-checking bench for the quiet chopper mode control block
// Assumes: 200 MHz clock, pins driven in step with the clock
// Notes:   Pin effects are sampled after a margin over the three-stage sync
`timescale 1ns/100ps
module testbench
    import quiet_chop_pkg::*;
;
    logic        ref_clk;
    logic        sys_rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        microstep_pin;
    logic        chopper_select_pin;
    logic        fullstep_pulse;
    logic [7:0]  velocity_level;
    logic signed [7:0] current_error;
    logic        quiet_chopper_active;
    logic        current_chopper_active;
    logic [7:0]  amplitude;
    logic [7:0]  gradient_in_use;
    logic        pwm_cycle_start;
    logic        chopper_phase;
    pwm_conf_s   cfg;
    int          num_errors;
    int          n_checks;

    host_model i_host (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    quiet_chopper_mode_control i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .microstep_pin(microstep_pin), .chopper_select_pin(chopper_select_pin),
        .fullstep_pulse(fullstep_pulse), .velocity_level(velocity_level),
        .current_error(current_error), .quiet_chopper_active(quiet_chopper_active),
        .current_chopper_active(current_chopper_active), .amplitude(amplitude),
        .gradient_in_use(gradient_in_use), .pwm_cycle_start(pwm_cycle_start),
        .chopper_phase(chopper_phase));

    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic settle(input logic v);
        for (int i = 0; i < 20 && quiet_chopper_active !== v; i++) @(posedge ref_clk);
    endtask : settle

    task automatic t_reset_values;
        logic [31:0] d;
        host_model_rd: begin end
        i_host.rd(PWM_CONFIG_OFS, d);      chk(d, 32'h0000100c, "pwm reset");
        i_host.rd(QUIET_THRESHOLD_OFS, d); chk(d, 32'h0, "thr reset");
        i_host.rd(STEP_INTERVAL_OFS, d);   chk(d, 32'h000fffff, "standstill");
        i_host.rd(8'h14, d);               chk(d, 32'h0, "unmapped");
        chk(quiet_chopper_active, 1'b1, "quiet at rest");
        i_host.rd(CHOPPER_STATUS_OFS, d);  chk(d, 32'h00010000, "status");
        i_host.wr(QUIET_THRESHOLD_OFS, 32'hffffffff);
        i_host.rd(QUIET_THRESHOLD_OFS, d); chk(d, 32'h000fffff, "thr max");
        i_host.wr(QUIET_THRESHOLD_OFS, 32'h0);
    endtask : t_reset_values

    task automatic t_forward_limit;
        cfg.user_offset_value      = 8'h40;
        cfg.user_gradient_value    = 8'h80;
        cfg.switch_amplitude_limit = 4'h2;
        velocity_level <= 8'h80;
        i_host.wr(GLOBAL_CONFIG_OFS, 32'h1);
        i_host.wr(PWM_CONFIG_OFS, cfg);
        repeat (8) @(posedge ref_clk);
        chk(amplitude, 8'h80, "forward amp");
        chk(gradient_in_use, 8'h80, "user grad");
        cfg.user_offset_value = 8'hff;
        i_host.wr(PWM_CONFIG_OFS, cfg);
        repeat (8) @(posedge ref_clk);
        chk(amplitude, 8'hff, "amp clamp 255");
        i_host.wr(GLOBAL_CONFIG_OFS, 32'h0);
        settle(1'b1);
        @(posedge ref_clk);
        chk(amplitude <= 8'h20, 1'b1, "switch limit");
    endtask : t_forward_limit

    task automatic t_disable_xor;
        for (int i = 0; i < 4; i++) begin
            i_host.wr(GLOBAL_CONFIG_OFS, {31'h0, i[1]});
            chopper_select_pin <= i[0];
            repeat (8) @(posedge ref_clk);
            chk(quiet_chopper_active, !(i[1] ^ i[0]), "quiet");
            chk(current_chopper_active, i[1] ^ i[0], "current");
        end
        chopper_select_pin <= 1'b0;
        i_host.wr(GLOBAL_CONFIG_OFS, 32'h0);
        // Let the pin pass its synchroniser before waiting for the mode
        repeat (8) @(posedge ref_clk);
        settle(1'b1);
    endtask : t_disable_xor

    task automatic t_auto_tune;
        logic [7:0] a0;
        logic [7:0] g0;
        cfg.auto_scale_en    = 1'b1;
        cfg.auto_gradient_en = 1'b1;
        cfg.regulation_gain  = 4'h4;
        current_error <= 8'sd1;
        i_host.wr(PWM_CONFIG_OFS, cfg);
        repeat (4) @(posedge ref_clk);
        a0 = amplitude;
        g0 = gradient_in_use;
        fullstep_pulse <= 1'b1;
        @(posedge ref_clk);
        fullstep_pulse <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(amplitude, a0 + 8'h02, "gain step");
        chk(gradient_in_use, g0 + 8'h01, "grad tune");
    endtask : t_auto_tune

    task automatic steps(input int gap);
        for (int k = 0; k < 3; k++) begin
            microstep_pin <= 1'b1;
            repeat (gap / 2) @(posedge ref_clk);
            microstep_pin <= 1'b0;
            repeat (gap - gap / 2) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
    endtask : steps

    task automatic t_threshold;
        logic [31:0] d;
        i_host.wr(QUIET_THRESHOLD_OFS, 32'd100);
        for (int g = 99; g <= 100; g++) begin
            steps(g);
            i_host.rd(STEP_INTERVAL_OFS, d);
            chk(d, g, "interval");
            chk(quiet_chopper_active, g >= 100, "thr compare");
        end
    endtask : t_threshold

    task automatic wait_pwm(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pwm_cycle_start !== 1'b1 && n < 1100);
    endtask : wait_pwm

    task automatic t_chopper_frequency_select;
        int        n;
        logic      ph;
        int        per[3] = '{512, 256, 205};
        freq_sel_e sel[3] = '{FREQ_DIV_1024, FREQ_DIV_512, FREQ_DIV_410};
        for (int i = 0; i < 3; i++) begin
            cfg.chopper_frequency_select = sel[i];
            i_host.wr(PWM_CONFIG_OFS, cfg);
            wait_pwm(n);
            wait_pwm(n);
            ph = chopper_phase;
            wait_pwm(n);
            chk(n, per[i], "pwm period");
            chk(chopper_phase, !ph, "half rate");
        end
    endtask : t_chopper_frequency_select

    task automatic results;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        #300000;
        num_errors++;
        results();
    end

    initial begin
        sys_rst            = 1'b1;
        microstep_pin      = 1'b0;
        chopper_select_pin = 1'b0;
        fullstep_pulse     = 1'b0;
        velocity_level     = 8'h00;
        current_error      = 8'sd0;
        num_errors         = 0;
        n_checks           = 0;
        cfg                = PWM_CONF_RST;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_forward_limit();
        t_disable_xor();
        t_auto_tune();
        t_threshold();
        t_chopper_frequency_select();
        results();
    end
endmodule : testbench
